// >>> hdl/hls_top.sv
// hit latch serializer: 15 hit latches, any-hit trigger, 16-bit frame shifter
// assumes link pins come from the remote digitizer asynchronously to mclk_i
`timescale 1ns/100ps
`default_nettype none
module hls_top (
   // system clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          resetn_i,
   // link from the remote digitizer, active low
   input  wire logic                          master_clk_n_i,
   input  wire logic                          load_n_i,
   input  wire logic                          clear_n_i,
   // discriminator hits, active low, channel 1 in bit 0
   input  wire logic [hls_pkg::CHANNELS-1:0]  hit_n_i,
   // static trigger line select
   input  wire logic [hls_pkg::TRIG_SEL_W-1:0] trig_sel_i,
   // open-drain trigger lines, the selected one pulled low on any hit
   input  wire logic [hls_pkg::TRIG_LINES-1:0] trig_line_i,
   output logic      [hls_pkg::TRIG_LINES-1:0] trig_line_o,
   output logic      [hls_pkg::TRIG_LINES-1:0] trig_line_oe_o,
   output logic                               trig_seen_o,
   // serial frame to the remote digitizer
   output logic                               sdata_o,
   // captured frames for local readout
   output logic                               frame_valid_o,
   input  wire logic                          frame_ready_i,
   output hls_pkg::hls_frame_t                frame_o,
   output logic                               capture_ready_o,
   output logic                               frame_drop_o,
   // frame length check
   output logic                               frame_len_err_o
);
   // synchronised pins
   hls_pkg::hls_link_t                   link;          // control pins
   logic [hls_pkg::TRIG_LINES-1:0]       trig_line_s;   // wired lines readback
   logic [hls_pkg::CHANNELS-1:0]         hit_n_s;       // hits, active low
   logic [hls_pkg::TRIG_SEL_W-1:0]       trig_sel_s;    // line select
   // decoded controls
   logic                                 mclk_prev_n;   // last master clock level
   logic                                 load_prev_n;   // last load level
   logic                                 mclk_edge;     // active master edge
   logic                                 load_act;      // load asserted
   logic                                 load_start;    // first cycle of load
   logic                                 clear_act;     // clear asserted
   logic [hls_pkg::CHANNELS-1:0]         hit_act;       // hits, active high
   // core state
   logic [hls_pkg::CHANNELS-1:0]         latch;         // hit latches
   logic [hls_pkg::FRAME_BITS-1:0]       shreg;         // serial shifter
   logic                                 any_hit;       // registered fast OR
   logic [hls_pkg::CNT_W-1:0]            edge_cnt;      // master edges per frame
   logic                                 frame_seen;    // a frame has started
   logic [hls_pkg::CNT_W-1:0]            shift_cnt;     // shifts since load
   hls_pkg::hls_frame_t                  next_frame;    // word to capture
   logic                                 cap_ready;     // buffer has room

   // returns the one-hot enable for a selected trigger line
   function automatic logic [hls_pkg::TRIG_LINES-1:0] line_onehot(
      input logic [hls_pkg::TRIG_SEL_W-1:0] sel
   );
      line_onehot = 4'h1 << sel;
   endfunction : line_onehot

   // control pins and wired lines share one synchroniser
   hls_sync #(
      .WIDTH     (7),
      .RESET_VAL (hls_pkg::LINK_IDLE)
   ) u_link_sync (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .async_i  ({master_clk_n_i, load_n_i, clear_n_i, trig_line_i}),
      .sync_o   ({link, trig_line_s})
   );

   // hit pins, idle high
   hls_sync #(
      .WIDTH     (hls_pkg::CHANNELS),
      .RESET_VAL (hls_pkg::HIT_IDLE)
   ) u_hit_sync (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .async_i  (hit_n_i),
      .sync_o   (hit_n_s)
   );

   // static select, still synchronised for safety
   hls_sync #(
      .WIDTH     (hls_pkg::TRIG_SEL_W),
      .RESET_VAL (hls_pkg::SEL_RESET)
   ) u_sel_sync (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .async_i  (trig_sel_i),
      .sync_o   (trig_sel_s)
   );

   // active-low pins turned into active-high strobes
   assign hit_act    = ~hit_n_s;
   assign load_act   = ~link.load_n;
   assign clear_act  = ~link.clear_n;
   assign mclk_edge  = mclk_prev_n && !link.mclk_n;
   assign load_start = load_prev_n && !link.load_n;

   // previous levels for edge detection, idle high
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         mclk_prev_n <= 1'b1;
         load_prev_n <= 1'b1;
      end else begin
         mclk_prev_n <= link.mclk_n;
         load_prev_n <= link.load_n;
      end
   end

   // one set-reset latch per channel; clear wins, hits in it are lost
   for (genvar c = 0; c < hls_pkg::CHANNELS; c++) begin : g_latch
      always_ff @(posedge mclk_i) begin
         if (!resetn_i) begin
            latch[c] <= hls_pkg::LATCH_RESET[c];
         end else if (clear_act) begin
            latch[c] <= 1'b0;
         end else if (hit_act[c]) begin
            latch[c] <= 1'b1;
         end
      end
   end

   // fast OR of all channels, drives the chosen open-drain line
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         any_hit        <= 1'b0;
         trig_line_oe_o <= '0;
      end else begin
         any_hit        <= |hit_act;
         trig_line_oe_o <= (|hit_act) ? line_onehot(trig_sel_s) : '0;
      end
   end

   // open-drain: only ever pull low
   assign trig_line_o = '0;

   // wired level seen on the chosen line, any card pulling it
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         trig_seen_o <= 1'b0;
      end else begin
         trig_seen_o <= |(~trig_line_s & line_onehot(trig_sel_s));
      end
   end

   // frame word: latched hits under a fixed fiducial
   always_comb begin
      next_frame.fiducial = hls_pkg::FIDUCIAL_VAL;
      next_frame.hit      = latch;
   end

   // shifter: level load, else one bit out per master edge
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         shreg <= hls_pkg::SHREG_RESET;
      end else if (load_act) begin
         shreg <= next_frame;
      end else if (mclk_edge) begin
         shreg <= {hls_pkg::SHIFT_FILL, shreg[hls_pkg::FRAME_BITS-1:1]};
      end
   end

   // bit 0 leaves first, active high
   assign sdata_o = shreg[0];

   // shifts since the last load, saturating
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         shift_cnt <= '0;
      end else if (load_act) begin
         shift_cnt <= '0;
      end else if (mclk_edge && shift_cnt != hls_pkg::CNT_MAX) begin
         shift_cnt <= shift_cnt + hls_pkg::CNT_ONE;
      end
   end

   // master edges between load starts must be sixteen
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         edge_cnt        <= '0;
         frame_seen      <= 1'b0;
         frame_len_err_o <= 1'b0;
      end else begin
         frame_len_err_o <= 1'b0;
         if (load_start) begin
            frame_seen      <= 1'b1;
            edge_cnt        <= mclk_edge ? hls_pkg::CNT_ONE : '0;
            frame_len_err_o <= frame_seen && (edge_cnt != hls_pkg::FRAME_LEN);
         end else if (mclk_edge && edge_cnt != hls_pkg::CNT_MAX) begin
            edge_cnt <= edge_cnt + hls_pkg::CNT_ONE;
         end
      end
   end

   // each captured frame also goes to a local readout buffer while it has room
   hls_buf2 #(
      .WIDTH ($bits(hls_pkg::hls_frame_t)),
      .DEPTH (hls_pkg::BUF_DEPTH)
   ) u_frame_buf (
      .mclk_i      (mclk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (load_start),
      .in_ready_o  (cap_ready),
      .in_data_i   (next_frame),
      .out_valid_o (frame_valid_o),
      .out_ready_i (frame_ready_i),
      .out_data_o  (frame_o)
   );

   assign capture_ready_o = cap_ready;

   // pulse when a frame finds the buffer full
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         frame_drop_o <= 1'b0;
      end else begin
         frame_drop_o <= load_start && !cap_ready;
      end
   end

   // a hit outside clear sets its latch and keeps it
   a_latch_set_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !clear_act |=> ((latch & $past(hit_act)) == $past(hit_act)))
      else $error("hit did not set its latch");

   // clear empties every latch next cycle
   a_latch_clear_all: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      clear_act |=> (latch == '0))
      else $error("latches not cleared");

   // load places the fiducial on top
   a_fiducial_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      load_act |=> shreg[hls_pkg::FIDUCIAL_POS])
      else $error("fiducial missing after load");

   // load copies the latched hits in order
   a_load_content: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      load_act |=> (shreg[hls_pkg::CHANNELS-1:0] == $past(latch)))
      else $error("loaded hits wrong");

   // one bit moves per master edge
   a_shift_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!load_act && mclk_edge) |=> (shreg[14:0] == $past(shreg[15:1])) && !shreg[15])
      else $error("shift step wrong");

   // no master edge, no movement
   a_shift_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!load_act && !mclk_edge) |=> $stable(shreg))
      else $error("shifter moved without master edge");

   // fiducial is the sixteenth bit out
   a_fiducial_last: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!load_act && shift_cnt == hls_pkg::SHIFT_LAST) |-> sdata_o)
      else $error("sixteenth bit not one");

   // the first bit out after load is channel one
   a_sdata_first: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      load_act |=> (sdata_o == $past(latch[0])))
      else $error("first serial bit not channel one");

   // fast OR follows the hits one cycle later
   a_any_hit_or: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> (any_hit == |$past(hit_act)))
      else $error("fast or wrong");

   // at most one line driven, exactly while any hit
   a_trig_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $onehot0(trig_line_oe_o) && ((trig_line_oe_o != '0) == any_hit))
      else $error("trigger routing wrong");

   // a full frame buffer shows as dropped word
   a_buf_drop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (load_start && !cap_ready) |=> frame_drop_o)
      else $error("drop not flagged");

   // a frame of the wrong length is flagged at the next load
   a_len_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (load_start && frame_seen && (edge_cnt != hls_pkg::FRAME_LEN)) |=> frame_len_err_o)
      else $error("frame length error not flagged");
endmodule : hls_top
`default_nettype wire

// >>> common/hls_pkg.sv
// constants and carrier types for the hit latch serializer
// assumes a 100 mhz system clock that samples every link pin
package hls_pkg;
   // channel and frame geometry
   localparam int CHANNELS   = 15;
   localparam int FRAME_BITS = 16;
   localparam int TRIG_LINES = 4;
   localparam int TRIG_SEL_W = 2;
   localparam int BUF_DEPTH  = 2;
   // clock rates and times in their own units
   localparam int SYS_CLK_MHZ    = 100;
   localparam int MASTER_CLK_MHZ = 16;
   localparam int SYS_PERIOD_NS  = 1000 / SYS_CLK_MHZ;
   localparam int LOAD_PULSE_NS  = 50;
   localparam int MIN_HIT_NS     = 200;
   // derived cycle counts, rounded up, never below one
   localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int MIN_HIT_CYC    = (MIN_HIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int SYNC_STAGES    = 2;
   // frame bit positions and counter values
   localparam int          FIDUCIAL_POS = 15;
   localparam logic        FIDUCIAL_VAL = 1'b1;
   localparam logic        SHIFT_FILL   = 1'b0;
   localparam int          CNT_W        = 5;
   localparam logic [4:0]  FRAME_LEN    = 5'h10;
   localparam logic [4:0]  SHIFT_LAST   = 5'h0f;
   localparam logic [4:0]  CNT_MAX      = 5'h1f;
   localparam logic [4:0]  CNT_ONE      = 5'h01;
   // values after reset
   localparam logic [15:0] SHREG_RESET  = 16'h0000;
   localparam logic [14:0] LATCH_RESET  = 15'h0000;
   localparam logic [6:0]  LINK_IDLE    = 7'h7f;
   localparam logic [14:0] HIT_IDLE     = 15'h7fff;
   localparam logic [1:0]  SEL_RESET    = 2'h0;
   // one serial frame: fiducial on top, channel 1 in bit 0
   typedef struct packed {
      logic                fiducial;
      logic [CHANNELS-1:0] hit;
   } hls_frame_t;
   // active-low link controls after synchronisation
   typedef struct packed {
      logic mclk_n;
      logic load_n;
      logic clear_n;
   } hls_link_t;
endpackage : hls_pkg

// >>> hdl/hls_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes each bit is an independent slow level or a clock far below mclk_i
`timescale 1ns/100ps
`default_nettype none
module hls_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   // asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;   // first stage, read only by second stage

   // two stages, reset to the idle level
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         meta   <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : hls_sync
`default_nettype wire

// >>> hdl/hls_buf2.sv
// small valid/ready buffer, two entries by default
// assumes both sides on mclk_i; either side may stall at any time
`timescale 1ns/100ps
`default_nettype none
module hls_buf2 #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             resetn_i,
   // filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // entry storage
   logic [PW-1:0]    wr_ptr;        // next slot to fill
   logic [PW-1:0]    rd_ptr;        // oldest slot
   logic [CW-1:0]    count;         // entries held
   logic             push;
   logic             pop;

   // honest full and empty
   assign in_ready_o  = (count != CNT_FULL);
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // entry storage, written only on push
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers wrap at the last slot
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PW'(1);
         end
      end
   end

   // occupancy
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + CW'(1);
      end else if (pop && !push) begin
         count <= count - CW'(1);
      end
   end
endmodule : hls_buf2
`default_nettype wire

// >>> sim/hls_remote_model.sv
// partner model of the remote digitizer: master clock, load, clear, serial sampling
// assumes one caller runs one frame at a time; pins idle high between frames
`timescale 1ns/100ps
`default_nettype none
module hls_remote_model (
   // system clock that times the link
   input  wire logic mclk_i,
   // serial data from the block
   input  wire logic sdata_i,
   // link pins, active low, idle high
   output logic      master_clk_n_o,
   output logic      load_n_o,
   output logic      clear_n_o
);
   // all link pins inactive at time zero
   initial begin
      master_clk_n_o = 1'b1;
      load_n_o       = 1'b1;
      clear_n_o      = 1'b1;
   end
   // one frame: load, then clear, then falls master clocks of half cycles per phase
   task run_frame(input int falls, input int half, output logic [15:0] word);
      word = 16'h0000;
      @(negedge mclk_i);
      load_n_o = 1'b0;
      repeat (5) @(negedge mclk_i);       // about 50 ns
      load_n_o = 1'b1;
      repeat (2) @(negedge mclk_i);
      clear_n_o = 1'b0;
      repeat (5) @(negedge mclk_i);
      clear_n_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      // clock stands still outside the frame
      for (int i = 0; i < falls; i++) begin
         repeat (half) @(negedge mclk_i);
         word[i] = sdata_i;               // settled bit just before its fall
         master_clk_n_o = 1'b0;
         repeat (half) @(negedge mclk_i);
         master_clk_n_o = 1'b1;
      end
   endtask : run_frame
endmodule : hls_remote_model
`default_nettype wire

// >>> sim/tb.sv
// testbench for the hit latch serializer: frames, trigger, frame buffer, length check
// assumes hls_remote_model drives the link; inputs change at falling edges
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                mclk_i    = 1'b0;     // system clock
   logic                resetn_i  = 1'b0;     // synchronous reset
   logic [14:0]         hit_n     = 15'h7fff; // discriminator hits, idle high
   logic [1:0]          trig_sel  = 2'h0;     // trigger line select
   logic [3:0]          ext_pull  = 4'h0;     // another card pulling a line low
   logic                fready    = 1'b0;     // readout ready
   wire logic           mclk_n, load_n, clear_n; // link pins from the model
   wire logic [3:0]     trig_line, trig_o, trig_oe;
   logic                trig_seen, sdata, fvalid, cap_rdy, drop, len_err;
   hls_pkg::hls_frame_t frame;
   int                  bad_count = 0, samples_checked = 0, cycles = 0;
   logic                drop_seen = 1'b0, err_seen = 1'b0; // sticky pulse catchers
   logic [15:0]         w;                    // word seen by the model

   // wired level of the open-drain lines, pulled up
   assign trig_line = ~((trig_oe & ~trig_o) | ext_pull);

   always #5 mclk_i = ~mclk_i;

   hls_top u_hls_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .master_clk_n_i(mclk_n),
      .load_n_i(load_n), .clear_n_i(clear_n), .hit_n_i(hit_n), .trig_sel_i(trig_sel),
      .trig_line_i(trig_line), .trig_line_o(trig_o), .trig_line_oe_o(trig_oe),
      .trig_seen_o(trig_seen), .sdata_o(sdata), .frame_valid_o(fvalid),
      .frame_ready_i(fready), .frame_o(frame), .capture_ready_o(cap_rdy),
      .frame_drop_o(drop), .frame_len_err_o(len_err));

   hls_remote_model u_hls_remote_model (.mclk_i(mclk_i), .sdata_i(sdata),
      .master_clk_n_o(mclk_n), .load_n_o(load_n), .clear_n_o(clear_n));

   // verdict and end of run
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // cycle ceiling and one-cycle pulse catchers
   always @(posedge mclk_i) begin
      cycles++;
      if (drop === 1'b1) drop_seen <= 1'b1;
      if (len_err === 1'b1) err_seen <= 1'b1;
      if (cycles == 20000) begin
         bad_count++;
         $display("[ERR] %0t timeout", $time);
         close_out();
      end
   end

   // one comparison
   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // hits low for 200 ns, then idle
   task hit_pulse(input logic [14:0] mask);
      hit_n = ~mask;
      repeat (20) @(negedge mclk_i);
      hit_n = 15'h7fff;
      repeat (5) @(negedge mclk_i);
   endtask : hit_pulse

   // take the oldest buffered word and compare it
   task pop(input logic [15:0] exp);
      chk({15'h0, fvalid}, 16'h0001, "buffer valid");
      chk(frame, exp, "buffer word");
      fready = 1'b1;
      @(negedge mclk_i);
      fready = 1'b0;
      // let an edge pass so a following pop never retoggles ready at once
      @(negedge mclk_i);
   endtask : pop

   // quiet outputs after reset
   task t_reset;
      chk({12'h0, trig_oe}, 16'h0000, "oe after reset");
      chk({13'h0, sdata, fvalid, drop}, 16'h0000, "outputs after reset");
      $display("test reset done");
   endtask : t_reset

   // latch hits, shift one frame, check serial word, fill bit and buffer
   task t_frame(input logic [14:0] mask);
      hit_pulse(mask);
      u_hls_remote_model.run_frame(16, 4, w);
      chk(w, {1'b1, mask}, "serial word");
      chk({1'b0, w[14:0]}, {1'b0, mask}, "hits without fiducial");
      repeat (6) @(negedge mclk_i);
      chk({15'h0, sdata}, 16'h0000, "fill after frame");
      pop({1'b1, mask});
      $display("test frame %h done", mask);
   endtask : t_frame

   // every select: hit drives only its line; wired line seen low
   task t_trigger;
      for (int s = 0; s < 4; s++) begin
         trig_sel = s[1:0];
         repeat (4) @(negedge mclk_i);
         hit_n[s*3] = 1'b0;
         repeat (6) @(negedge mclk_i);
         chk({12'h0, trig_oe}, 16'h0001 << s, "oe one-hot");
         chk({11'h0, trig_o, trig_seen}, 16'h0001, "pull low seen");
         hit_n = 15'h7fff;
         repeat (8) @(negedge mclk_i);
         chk({11'h0, trig_oe, trig_seen}, 16'h0000, "oe released");
         ext_pull = 4'h1 << s;
         repeat (8) @(negedge mclk_i);
         chk({15'h0, trig_seen}, 16'h0001, "wired or seen");
         ext_pull = ~(4'h1 << s);
         repeat (8) @(negedge mclk_i);
         chk({15'h0, trig_seen}, 16'h0000, "other lines ignored");
         ext_pull = 4'h0;
      end
      u_hls_remote_model.run_frame(16, 4, w);
      chk(w, 16'h8249, "trigger hits latched");
      pop(16'h8249);
      $display("test trigger done");
   endtask : t_trigger

   // a short frame is flagged at the next load, a full one is not
   task t_len_err;
      err_seen = 1'b0;
      u_hls_remote_model.run_frame(15, 4, w);
      pop(16'h8000);
      chk({15'h0, err_seen}, 16'h0000, "no error after full frame");
      u_hls_remote_model.run_frame(16, 4, w);
      pop(16'h8000);
      chk({15'h0, err_seen}, 16'h0001, "short frame flagged");
      err_seen = 1'b0;
      u_hls_remote_model.run_frame(16, 4, w);
      pop(16'h8000);
      chk({15'h0, err_seen}, 16'h0000, "full frame clean");
      $display("test length done");
   endtask : t_len_err

   // readout stalls over three slow frames: two kept, third lost
   task t_buffer;
      drop_seen = 1'b0;
      for (int k = 0; k < 3; k++) begin
         hit_pulse(15'h0001 << k);
         u_hls_remote_model.run_frame(16, 6, w);
         chk(w, {1'b1, 15'h0001 << k}, "slow serial word");
         if (k == 1) chk({14'h0, cap_rdy, drop_seen}, 16'h0000, "full, no drop yet");
      end
      chk({15'h0, drop_seen}, 16'h0001, "drop when full");
      pop(16'h8001);
      pop(16'h8002);
      chk({14'h0, fvalid, cap_rdy}, 16'h0001, "buffer empty");
      $display("test buffer done");
   endtask : t_buffer

   // main sequence
   initial begin
      repeat (20) @(negedge mclk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      t_reset();
      t_frame(15'h0001);
      t_frame(15'h4000);
      t_frame(15'h5555);
      t_frame(15'h0000);
      t_frame(15'h7fff);
      t_trigger();
      t_len_err();
      t_buffer();
      close_out();
   end
endmodule : tb
`default_nettype wire
